// [src/cct_map.vh]
`ifndef CCT_MAP_VH
`define CCT_MAP_VH
`define CCT_NUM_TIMERS 12
`define CCT_SEC_W      25
`define CCT_CLK_NS     100
`define CCT_TICK_NS    1000000000
`define CCT_PERM_OFS   12'h000
`define CCT_CAL_OFS    12'h004
`define CCT_TMR_BASE   12'h100
`define CCT_CTRL_OFS   5'h00
`define CCT_DUR_OFS    5'h04
`define CCT_RPT_OFS    5'h08
`define CCT_MATCH_OFS  5'h0c
`define CCT_REM_OFS    5'h10
`define CCT_RIN_OFS    5'h14
`define CCT_STAT_OFS   5'h18
`define CCT_EN_BIT     0
`define CCT_RPT_BIT    1
`define CCT_SELF_BIT   2
`define CCT_JOB_BIT    3
`define CCT_START_BIT  8
`define CCT_RESET_BIT  9
`define CCT_SEC_POS    0
`define CCT_MIN_POS    6
`define CCT_HOUR_POS   12
`define CCT_DATE_POS   17
`define CCT_MON_POS    23
`define CCT_ANY6       6'h3f
`define CCT_ANY5       5'h1f
`define CCT_ANY4       4'hf
`define CCT_CTRL_RST   4'h0
`define CCT_CTRL1_RST  4'hb
`define CCT_RPT1_RST   25'd86400
`define CCT_MATCH_RST  27'h7ffffff
`define CCT_HH_POS     16
`define CCT_MM_POS     8
`endif

// [src/cct_cal_match.v]
`timescale 1ns/1ns
`default_nettype none
`include "cct_map.vh"
module cct_cal_match (
   // Programmed fields and current calendar, same packing
   input  wire [26:0] cfg,
   input  wire [26:0] cal,
   // Result
   output wire        hit
);
   wire [5:0] c_sec = cfg[`CCT_SEC_POS +: 6];
   wire [5:0] c_min = cfg[`CCT_MIN_POS +: 6];
   wire [4:0] c_hr  = cfg[`CCT_HOUR_POS +: 5];
   wire [5:0] c_dat = cfg[`CCT_DATE_POS +: 6];
   wire [3:0] c_mon = cfg[`CCT_MON_POS +: 4];

   // Exact compare of the raw calendar, an all-ones field matching anything; a day the month lacks never occurs
   assign hit = (c_sec == `CCT_ANY6 || c_sec == cal[`CCT_SEC_POS +: 6])
             && (c_min == `CCT_ANY6 || c_min == cal[`CCT_MIN_POS +: 6])
             && (c_hr  == `CCT_ANY5 || c_hr  == cal[`CCT_HOUR_POS +: 5])
             && (c_dat == `CCT_ANY6 || c_dat == cal[`CCT_DATE_POS +: 6])
             && (c_mon == `CCT_ANY4 || c_mon == cal[`CCT_MON_POS +: 4]);
endmodule
`default_nettype wire

// [src/cct_timer.v]
`timescale 1ns/1ns
`default_nettype none
module cct_timer #(
   parameter W = 25
) (
   // Clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // Control
   input  wire         tick,
   input  wire         en,
   input  wire         rpt_mode,
   input  wire         start,
   input  wire         clr,
   input  wire [W-1:0] dur,
   input  wire [W-1:0] rpt,
   // State
   output reg  [W-1:0] rem_q,
   output reg  [W-1:0] rin_q,
   output reg          cyc_q,
   output reg          act_q,
   output reg          go_q
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rem_q <= {W{1'b0}};
         rin_q <= {W{1'b0}};
         cyc_q <= 1'b0;
         act_q <= 1'b0;
         go_q  <= 1'b0;
      end else begin
         go_q <= 1'b0;
         if (clr || !en) begin
            rem_q <= {W{1'b0}};
            rin_q <= {W{1'b0}};
            cyc_q <= 1'b0;
            act_q <= 1'b0;
         end else if (start) begin
            rem_q <= dur;
            rin_q <= rpt;
            cyc_q <= rpt_mode && (rpt != {W{1'b0}});
            act_q <= (dur != {W{1'b0}});
            go_q  <= 1'b1;
         end else if (tick) begin
            if (rem_q != {W{1'b0}}) begin
               rem_q <= rem_q - 1'b1;
               if (rem_q == {{(W-1){1'b0}}, 1'b1})
                  act_q <= 1'b0;
            end
            if (cyc_q) begin
               // Repeat counted from the start, so a restart reloads both
               if (rin_q <= {{(W-1){1'b0}}, 1'b1}) begin
                  rem_q <= dur;
                  rin_q <= rpt;
                  act_q <= (dur != {W{1'b0}});
                  go_q  <= 1'b1;
               end else begin
                  rin_q <= rin_q - 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// [src/cct_top.v]
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "cct_map.vh"
module cct_top #(
   parameter N           = `CCT_NUM_TIMERS,
   parameter W           = `CCT_SEC_W,
   parameter TICK_CYCLES = `CCT_TICK_NS / `CCT_CLK_NS
) (
   // Clock and reset
   input  wire          pclk,
   input  wire          presetn,
   // APB slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   // Calendar source pins, packed like a match word
   input  wire [26:0]   cal_time,
   // Job-action trigger requests, one-cycle pulses
   input  wire [N-1:0]  job_start,
   // Events
   output reg  [N-1:0]  timer_active_q,
   output reg           ctr1_dec_q
);
   integer i;

   localparam [W-1:0] SEC_PER_HR  = 3600;
   localparam [W-1:0] SEC_PER_MIN = 60;

   // Configuration store
   reg  [3:0]   ctrl_q  [0:N-1];
   reg  [W-1:0] dur_q   [0:N-1];
   reg  [W-1:0] rpt_q   [0:N-1];
   reg  [26:0]  match_q [0:N-1];
   reg          perm_q;
   reg  [N-1:0] start_cmd_q;
   reg  [N-1:0] clr_cmd_q;

   // Channel state
   wire [W-1:0] rem    [0:N-1];
   wire [W-1:0] rin    [0:N-1];
   wire [N-1:0] cyc;
   wire [N-1:0] act;
   wire [N-1:0] go;
   wire [N-1:0] cal_hit;
   wire [N-1:0] fire;

   // Calendar synchroniser and second-change detect
   reg  [26:0] cal_s1_q;
   reg  [26:0] cal_s2_q;
   reg  [26:0] cal_s3_q;
   reg  [5:0]  sec_prev_q;
   wire        cal_settled;
   wire        new_sec;

   // One-second time base
   reg  [31:0] tick_cnt_q;
   reg         tick_q;

   // Bus decode
   reg  [31:0] rd_d;
   reg         hit_d;
   wire [11:0] tsub;
   wire [3:0]  tidx;
   wire [4:0]  tofs;
   wire        tsel;
   wire        setup;
   wire        wr_acc;

   function [5:0] days_in_month;
      input [3:0] m;
      begin
         case (m)
            4'd2:    days_in_month = 6'd29;
            4'd4:    days_in_month = 6'd30;
            4'd6:    days_in_month = 6'd30;
            4'd9:    days_in_month = 6'd30;
            4'd11:   days_in_month = 6'd30;
            default: days_in_month = 6'd31;
         endcase
      end
   endfunction

   // Out-of-range picks are refused as a whole; the old match stays
   function match_ok;
      input [26:0] w;
      reg   [5:0]  s;
      reg   [5:0]  mi;
      reg   [4:0]  h;
      reg   [5:0]  d;
      reg   [3:0]  mo;
      begin
         s  = w[`CCT_SEC_POS +: 6];
         mi = w[`CCT_MIN_POS +: 6];
         h  = w[`CCT_HOUR_POS +: 5];
         d  = w[`CCT_DATE_POS +: 6];
         mo = w[`CCT_MON_POS +: 4];
         match_ok = (s == `CCT_ANY6 || s <= 6'd59)
                 && (mi == `CCT_ANY6 || mi <= 6'd59)
                 && (h == `CCT_ANY5 || h <= 5'd23)
                 && (mo == `CCT_ANY4 || (mo >= 4'd1 && mo <= 4'd12))
                 && (d == `CCT_ANY6 || (d >= 6'd1 && d <= days_in_month(mo)));
      end
   endfunction

   // Seconds to hh:mm:ss packed for readout
   function [31:0] to_hms;
      input [W-1:0] t;
      reg   [W-1:0] hh;
      reg   [W-1:0] rest;
      reg   [W-1:0] mm;
      reg   [W-1:0] ss;
      begin
         hh   = t / SEC_PER_HR;
         rest = t - hh * SEC_PER_HR;
         mm   = rest / SEC_PER_MIN;
         ss   = rest - mm * SEC_PER_MIN;
         to_hms = 32'h0;
         to_hms[`CCT_HH_POS +: 16] = hh[15:0];
         to_hms[`CCT_MM_POS +: 6]  = mm[5:0];
         to_hms[5:0]               = ss[5:0];
      end
   endfunction

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == TICK_CYCLES - 1) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
         tick_q     <= 1'b0;
      end
   end

   // Pins change asynchronously; fields settle well inside one second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_s1_q   <= 27'h0;
         cal_s2_q   <= 27'h0;
         cal_s3_q   <= 27'h0;
         sec_prev_q <= 6'h0;
      end else begin
         cal_s1_q   <= cal_time;
         cal_s2_q   <= cal_s1_q;
         cal_s3_q   <= cal_s2_q;
         if (cal_settled)
            sec_prev_q <= cal_s3_q[`CCT_SEC_POS +: 6];
      end
   end

   // Bits of one change may land a cycle apart; trust a word only when two samples agree
   assign cal_settled = (cal_s2_q == cal_s3_q);

   // Each new calendar second is checked once, so a match fires once
   assign new_sec = cal_settled && (cal_s3_q[`CCT_SEC_POS +: 6] != sec_prev_q);

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : ch
         cct_cal_match u_match (
            .cfg (match_q[g]),
            .cal (cal_s3_q),
            .hit (cal_hit[g])
         );

         assign fire[g] = ctrl_q[g][`CCT_EN_BIT]
                       && (job_start[g]
                        || start_cmd_q[g]
                        || (ctrl_q[g][`CCT_SELF_BIT] && new_sec && cal_hit[g]));

         cct_timer #(
            .W (W)
         ) u_tmr (
            .pclk     (pclk),
            .presetn  (presetn),
            .tick     (tick_q),
            .en       (ctrl_q[g][`CCT_EN_BIT]),
            .rpt_mode (ctrl_q[g][`CCT_RPT_BIT]),
            .start    (fire[g]),
            .clr      (clr_cmd_q[g]),
            .dur      (dur_q[g]),
            .rpt      (rpt_q[g]),
            .rem_q    (rem[g]),
            .rin_q    (rin[g]),
            .cyc_q    (cyc[g]),
            .act_q    (act[g]),
            .go_q     (go[g])
         );
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_active_q <= {N{1'b0}};
         ctr1_dec_q     <= 1'b0;
      end else begin
         timer_active_q <= act;
         ctr1_dec_q     <= go[0] && ctrl_q[0][`CCT_JOB_BIT];
      end
   end

   assign tsub   = paddr - `CCT_TMR_BASE;
   assign tidx   = tsub[8:5];
   assign tofs   = tsub[4:0];
   assign tsel   = (paddr >= `CCT_TMR_BASE) && (tsub[11:9] == 3'h0) && (tidx < N);
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite && pready;

   always @* begin
      rd_d  = 32'h0;
      hit_d = 1'b1;
      if (paddr == `CCT_PERM_OFS) begin
         rd_d[0] = perm_q;
      end else if (paddr == `CCT_CAL_OFS) begin
         rd_d[26:0] = cal_s3_q;
      end else if (tsel) begin
         case (tofs)
            `CCT_CTRL_OFS:  rd_d[3:0]   = ctrl_q[tidx];
            `CCT_DUR_OFS:   rd_d[W-1:0] = dur_q[tidx];
            `CCT_RPT_OFS:   rd_d[W-1:0] = rpt_q[tidx];
            `CCT_MATCH_OFS: rd_d[26:0]  = match_q[tidx];
            `CCT_REM_OFS:   rd_d = to_hms(rem[tidx]);
            `CCT_RIN_OFS: begin
               if (rem[tidx] == {W{1'b0}} && cyc[tidx])
                  rd_d = to_hms(rin[tidx]);
               else
                  rd_d = 32'h0;
            end
            `CCT_STAT_OFS:  rd_d[1:0] = {cyc[tidx], act[tidx]};
            default:        hit_d = 1'b0;
         endcase
      end else begin
         hit_d = 1'b0;
      end
   end

   // Zero-wait slave: data sampled in setup, ready in first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h0 : rd_d;
         pready  <= 1'b1;
         pslverr <= !hit_d;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         perm_q      <= 1'b0;
         start_cmd_q <= {N{1'b0}};
         clr_cmd_q   <= {N{1'b0}};
         for (i = 0; i < N; i = i + 1) begin
            ctrl_q[i]  <= (i == 0) ? `CCT_CTRL1_RST : `CCT_CTRL_RST;
            dur_q[i]   <= {W{1'b0}};
            rpt_q[i]   <= (i == 0) ? `CCT_RPT1_RST : {W{1'b0}};
            match_q[i] <= `CCT_MATCH_RST;
         end
      end else begin
         start_cmd_q <= {N{1'b0}};
         clr_cmd_q   <= {N{1'b0}};
         if (wr_acc && !pslverr) begin
            if (paddr == `CCT_PERM_OFS) begin
               perm_q <= pwdata[0];
            end else if (tsel) begin
               case (tofs)
                  `CCT_CTRL_OFS: begin
                     ctrl_q[tidx] <= pwdata[3:0];
                     start_cmd_q[tidx] <= pwdata[`CCT_START_BIT] && perm_q;
                     clr_cmd_q[tidx]   <= pwdata[`CCT_RESET_BIT];
                  end
                  `CCT_DUR_OFS: dur_q[tidx] <= pwdata[W-1:0];
                  `CCT_RPT_OFS: rpt_q[tidx] <= pwdata[W-1:0];
                  `CCT_MATCH_OFS: begin
                     if (match_ok(pwdata[26:0]))
                        match_q[tidx] <= pwdata[26:0];
                  end
                  default: ;
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// [sim/cct_top_props.sv]
`timescale 1ns/1ns
`default_nettype none
module cct_top_props #(
   parameter N           = 12,
   parameter W           = 25,
   parameter TICK_CYCLES = 10
) (
   // Clock and reset
   input wire logic         pclk,
   input wire logic         presetn,
   // APB
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [11:0]  paddr,
   input wire logic [31:0]  pwdata,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   // Sources and events
   input wire logic [26:0]  cal_time,
   input wire logic [N-1:0] job_start,
   input wire logic [N-1:0] timer_active_q,
   input wire logic         ctr1_dec_q
);
   // Shadow of the few control bits the properties depend on
   logic [3:0] ctl0_q;
   logic       en1_q;
   logic       dur1_q;
   wire        wr_acc = psel && penable && pready && pwrite;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl0_q <= 4'hb;
         en1_q  <= 1'b0;
         dur1_q <= 1'b0;
      end else if (wr_acc) begin
         if (paddr == 12'h100)
            ctl0_q <= pwdata[3:0];
         if (paddr == 12'h120)
            en1_q <= pwdata[0];
         // Two seconds or more, so no tick can empty it before the event shows
         if (paddr == 12'h124)
            dur1_q <= |pwdata[W-1:1];
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_rdy_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_rdy_once: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_map: assert property (psel && !penable && paddr == 12'h11c |=> pready && pslverr)
      else $error("unmapped access not refused");
   chk_rst_quiet: assert property ($rose(presetn) |-> !pready && timer_active_q == '0 && !ctr1_dec_q)
      else $error("outputs busy after reset");
   chk_job_lat: assert property (job_start[1] && en1_q && dur1_q && !wr_acc |-> ##2 timer_active_q[1])
      else $error("job request did not start timer");
   chk_dis_never: assert property (!en1_q [*3] |-> !timer_active_q[1])
      else $error("disabled timer active");
   chk_rst_now: assert property (wr_acc && paddr == 12'h120 && pwdata[9] |-> ##3 !timer_active_q[1])
      else $error("reset command left timer active");
   chk_dec_job: assert property (job_start[0] && ctl0_q[0] && ctl0_q[3] |-> ##[1:2] ctr1_dec_q)
      else $error("no counter decrement on start");
   chk_dec_cause: assert property (ctr1_dec_q |-> $past(ctl0_q[3]) || $past(ctl0_q[3], 2))
      else $error("decrement without job bit");
endmodule

bind cct_top cct_top_props #(.N(N), .W(W), .TICK_CYCLES(TICK_CYCLES)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cal_time(cal_time), .job_start(job_start), .timer_active_q(timer_active_q),
   .ctr1_dec_q(ctr1_dec_q));
`default_nettype wire

// [sim/cct_top_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module cct_top_tb_top;
   localparam int N = 12;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ctr1_dec_q;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, r;
   logic [26:0]  cal_time, tm [5], tc [5], bad [8];
   logic [N-1:0] job_start, timer_active_q;
   logic         tx [5];
   int           n_errors, check_count, cyc, n, a;

`define CHK(nm, x, g) begin check_count++; if ((g) !== (x)) begin n_errors++; \
   $display("Error %s exp %0h got %0h", nm, x, g); end end

   cct_top #(.TICK_CYCLES(10)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cal_time(cal_time), .job_start(job_start), .timer_active_q(timer_active_q),
      .ctr1_dec_q(ctr1_dec_q));

   always #50 pclk = ~pclk;

   function automatic logic [26:0] mk(input int mo, dt, hr, mi, se);
      return {mo[3:0], dt[5:0], hr[4:0], mi[5:0], se[5:0]};
   endfunction

   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask

   task automatic rdc(input logic [11:0] ad, input logic [31:0] x);
      apb(1'b0, ad, 32'h0);
      `CHK($sformatf("reg %h", ad), x, r)
   endtask

   // Bounded wait on one event line, edges counted in n
   task automatic wt(input int i, input logic v);
      n = 0;
      while (timer_active_q[i] !== v && n < 2000) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic jp(input int i);
      @(posedge pclk);
      job_start[i] <= 1'b1;
      @(posedge pclk);
      job_start[i] <= 1'b0;
      @(posedge pclk);
      #1;
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("Error timeout exp 0 got 1");
         finish_test();
      end
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite} = '0;
      {paddr, pwdata, cal_time, job_start} = '0;
      tm = '{mk(15, 63, 31, 0, 30), mk(15, 63, 31, 0, 30), mk(15, 63, 31, 0, 30),
             mk(15, 63, 31, 63, 30), mk(15, 63, 31, 63, 30)};
      tc = '{mk(1, 1, 5, 1, 30), mk(1, 1, 5, 0, 29), mk(1, 1, 5, 0, 30),
             mk(1, 1, 5, 7, 31), mk(1, 1, 5, 7, 30)};
      tx = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      bad = '{mk(15, 63, 31, 63, 60), mk(15, 63, 31, 60, 30), mk(15, 63, 24, 63, 30),
              mk(13, 63, 31, 63, 30), mk(0, 63, 31, 63, 30), mk(15, 0, 31, 63, 30),
              mk(2, 30, 31, 63, 30), mk(4, 31, 31, 63, 30)};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < N; i++) begin
         rdc(12'h100 + 12'(i * 32), (i == 0) ? 32'hb : 32'h0);
         rdc(12'h10c + 12'(i * 32), 32'h7ffffff);
      end
      rdc(12'h108, 32'd86400);
      rdc(12'h000, 32'h0);
      apb(1'b0, 12'h11c, 32'h0);
      `CHK("unmapped", 1'b1, e)
      $display("test reset values done");
      wr(12'h124, 32'd3725);
      wr(12'h120, 32'h101);
      repeat (5) @(posedge pclk);
      `CHK("no access", 1'b0, timer_active_q[1])
      wr(12'h000, 32'h1);
      wr(12'h120, 32'h101);
      wt(1, 1'b1);
      `CHK("manual start", 1'b1, timer_active_q[1])
      apb(1'b0, 12'h130, 32'h0);
      `CHK("remain hms", 1'b1, r == 32'h10205 || r == 32'h10204)
      wr(12'h120, 32'h201);
      rdc(12'h130, 32'h0);
      `CHK("reset now", 1'b0, timer_active_q[1])
      wr(12'h124, 32'd3);
      wr(12'h120, 32'h101);
      wt(1, 1'b1);
      wt(1, 1'b0);
      `CHK("run length", 1'b1, n >= 19 && n <= 31)
      repeat (60) @(posedge pclk);
      `CHK("one shot", 1'b0, timer_active_q[1])
      $display("test manual start done");
      jp(1);
      `CHK("job start", 1'b1, timer_active_q[1])
      jp(0);
      `CHK("counter dec", 1'b1, ctr1_dec_q)
      wr(12'h120, 32'h0);
      jp(1);
      wr(12'h120, 32'h100);
      repeat (3) @(posedge pclk);
      `CHK("disabled", 1'b0, timer_active_q[1])
      $display("test job and enable done");
      wr(12'h144, 32'd2);
      wr(12'h148, 32'd4);
      wr(12'h140, 32'h103);
      wt(2, 1'b1);
      rdc(12'h154, 32'h0);
      wt(2, 1'b0);
      apb(1'b0, 12'h154, 32'h0);
      `CHK("repeat in", 1'b1, r == 32'h1 || r == 32'h2)
      rdc(12'h158, 32'h2);
      wt(2, 1'b1);
      wt(2, 1'b0);
      a = n;
      wt(2, 1'b1);
      `CHK("period", 40, a + n)
      wr(12'h140, 32'h0);
      $display("test repeat done");
      wr(12'h164, 32'd3);
      wr(12'h160, 32'h5);
      for (int i = 0; i < 5; i++) begin
         wr(12'h16c, {5'h0, tm[i]});
         @(posedge pclk);
         cal_time <= tc[i];
         repeat (6) @(posedge pclk);
         #1;
         `CHK("self start", tx[i], timer_active_q[3])
         wr(12'h160, 32'h205);
      end
      rdc(12'h004, {5'h0, tc[4]});
      // Bad field values must leave the last good word in place
      for (int i = 0; i < 8; i++) begin
         wr(12'h16c, {5'h0, bad[i]});
         rdc(12'h16c, {5'h0, tm[4]});
      end
      $display("test calendar done");
      finish_test();
   end
endmodule
`default_nettype wire
